// file: common/sg_pkg.sv
// Constants and types shared by the switchgear supervisor
package sg_pkg;
  // Bus and field widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int TIME_W = 16;
  localparam int POS_W = 2;
  localparam int CMD_W = 4;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFFS = 8'h00;
  localparam logic [ADDR_W-1:0] CMD_OFFS = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFFS = 8'h08;
  localparam logic [ADDR_W-1:0] BRK_TIME_OFFS = 8'h0c;
  localparam logic [ADDR_W-1:0] TRK_TIME_OFFS = 8'h10;
  localparam logic [ADDR_W-1:0] SETTLE_OFFS = 8'h14;
  // Control fields
  localparam int CTRL_ILOCK_BIT = 0;
  localparam int CTRL_PROT_BIT = 1;
  localparam int CTRL_BRK_CL_BIT = 2;
  localparam int CTRL_BRK_OP_BIT = 3;
  localparam int CTRL_TRK_CL_BIT = 4;
  localparam int CTRL_TRK_OP_BIT = 5;
  localparam logic [DATA_W-1:0] CTRL_MASK = 32'h0000_003f;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_003c;
  // Command pulse bits
  localparam int CMD_BRK_CLOSE = 0;
  localparam int CMD_BRK_OPEN = 1;
  localparam int CMD_TRK_INSERT = 2;
  localparam int CMD_TRK_WITHDRAW = 3;
  // Status fields
  localparam int STAT_BRK_POS_LSB = 0;
  localparam int STAT_TRK_POS_LSB = 2;
  localparam int STAT_PLUG_BIT = 4;
  localparam int STAT_READY_BIT = 5;
  localparam int STAT_REFUSED_BIT = 6;
  localparam int STAT_BLOCK_BIT = 7;
  localparam int STAT_CMD_LSB = 8;
  localparam int STAT_BUSY_LSB = 12;
  // Timing fields, counted in ticks
  localparam int CLOSE_T_LSB = 0;
  localparam int OPEN_T_LSB = 16;
  localparam int BRK_SETTLE_LSB = 0;
  localparam int TRK_SETTLE_LSB = 16;
  localparam logic [DATA_W-1:0] TIME_RESET = 32'h0064_0064;
  localparam logic [DATA_W-1:0] SETTLE_RESET = 32'h0000_0000;
  // Timer tick derived from the system clock
  localparam int unsigned CLK_FREQ_MHZ = 200;
  localparam int unsigned TICK_PERIOD_US = 1000;
  localparam int unsigned TICK_CYCLES_DEF = TICK_PERIOD_US * CLK_FREQ_MHZ;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Position codes and travel states
  typedef enum logic [POS_W-1:0] {
    POS_MID = 2'h0, POS_OPEN = 2'h1, POS_CLOSED = 2'h2, POS_FAULT = 2'h3
  } pos_t;
  typedef enum logic [3:0] {
    MV_IDLE = 4'h1, MV_CLOSE = 4'h2, MV_OPEN = 4'h4, MV_SETTLE = 4'h8
  } motion_t;
endpackage

// file: verilog/tick_gen.sv
// Divider giving a one-cycle timer tick enable
`timescale 1ns/100ps
`default_nettype none
module tick_gen
  import sg_pkg::*;
#(
  parameter int unsigned PERIOD = TICK_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  localparam int CW = $clog2(PERIOD + 1);
  logic [CW-1:0] cnt_reg;
  // Free running count, wraps at the period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else if (cnt_reg == CW'(PERIOD - 1)) begin
      cnt_reg <= '0;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: verilog/switchgear_unit.sv
// Position supervision and command timing for one switchgear unit
`timescale 1ns/100ps
`default_nettype none
module switchgear_unit
  import sg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic aux_closed,
  input wire logic aux_open,
  input wire logic closed_used,
  input wire logic open_used,
  input wire logic force_open,
  input wire logic close_req,
  input wire logic open_req,
  input wire logic [TIME_W-1:0] close_time,
  input wire logic [TIME_W-1:0] open_time,
  input wire logic [TIME_W-1:0] settle_time,
  output var pos_t pos,
  output logic close_cmd,
  output logic open_cmd,
  output logic busy
);
  motion_t state_reg;
  logic [TIME_W-1:0] timer_reg;
  logic fail_reg;
  logic target_reg;
  logic fb_closed;
  logic fb_open;
  logic reached;
  // Feedback decode; one contact alone still gives both ends
  always_comb begin
    fb_closed = 1'b0;
    fb_open = 1'b0;
    if (closed_used && open_used) begin
      fb_closed = aux_closed & ~aux_open;
      fb_open = aux_open & ~aux_closed;
    end else if (closed_used) begin
      fb_closed = aux_closed;
      fb_open = ~aux_closed;
    end else if (open_used) begin
      fb_open = aux_open;
      fb_closed = ~aux_open;
    end
    reached = target_reg ? fb_closed : fb_open;
  end
  assign busy = (state_reg != MV_IDLE);
  // Travel state, timer and command drive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= MV_IDLE; // R15
      timer_reg <= '0;
      close_cmd <= 1'b0;
      open_cmd <= 1'b0;
      fail_reg <= 1'b0;
      target_reg <= 1'b0;
    end else if (force_open) begin
      state_reg <= MV_IDLE; // R4
      timer_reg <= '0;
      close_cmd <= 1'b0;
      open_cmd <= 1'b0;
      fail_reg <= 1'b0;
    end else begin
      case (state_reg)
        MV_IDLE: begin
          if (close_req && !fb_closed) begin
            state_reg <= MV_CLOSE; // R14
            timer_reg <= close_time; // R11
            close_cmd <= 1'b1;
            target_reg <= 1'b1;
            fail_reg <= 1'b0;
          end else if (open_req && !fb_open) begin
            state_reg <= MV_OPEN;
            timer_reg <= open_time; // R11
            open_cmd <= 1'b1;
            target_reg <= 1'b0;
            fail_reg <= 1'b0;
          end else if (fail_reg && reached) begin
            fail_reg <= 1'b0;
          end
        end
        MV_CLOSE, MV_OPEN: begin
          if (reached) begin
            close_cmd <= 1'b0; // R9
            open_cmd <= 1'b0; // R10
            timer_reg <= settle_time;
            state_reg <= MV_SETTLE;
          end else if (timer_reg == '0) begin
            close_cmd <= 1'b0; // R9
            open_cmd <= 1'b0; // R10
            fail_reg <= 1'b1; // R14
            state_reg <= MV_IDLE;
          end else if (tick) begin
            timer_reg <= timer_reg - 1'b1; // R15
          end
        end
        MV_SETTLE: begin
          if (timer_reg == '0) begin
            state_reg <= MV_IDLE;
          end else if (tick) begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        default: state_reg <= MV_IDLE;
      endcase
    end
  end
  // Reported code; intermediate at reset and while a timer runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos <= POS_MID; // R15
    end else if (force_open) begin
      pos <= POS_OPEN; // R3
    end else if (state_reg != MV_IDLE) begin
      pos <= POS_MID; // R13
    end else if (fail_reg) begin
      pos <= POS_FAULT; // R14
    end else if (fb_closed) begin
      pos <= POS_CLOSED; // R1
    end else if (fb_open) begin
      pos <= POS_OPEN; // R1
    end else begin
      pos <= POS_FAULT; // R13
    end
  end
endmodule
`default_nettype wire

// file: verilog/withdrawable_switchgear_supervision.sv
// Top of the withdrawable switchgear supervisor with its register slave
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// R1: Each unit reports a 2-bit position code
// R2: Plug removal input raises plug withdrawn status
// R3: Withdrawn plug forces breaker code to open
// R4: Withdrawn plug blocks breaker position manipulation
// R5: Breaker and truck run as independent units
// R6: Optional interlock blocks withdrawal while breaker closed
// R7: Breaker takes four inputs, truck only two
// R8: At least one feedback contact stays assigned
// R9: Close command limited by close travel timeout
// R10: Open command limited by open travel timeout
// R11: Per-unit travel timeouts and optional settle delay
// R12: Protection commands may share control output relays
// R13: Equal feedback reads intermediate, then faulted
// R14: Close starts timer, ends closed or faulted
// R15: Tick-based timers, reset gives intermediate
module withdrawable_switchgear_supervision
  import sg_pkg::*;
#(
  // Long count, may be shortened in simulation
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic [STRB_W-1:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [DATA_W-1:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic BRK_AUX_CLOSED,
  input wire logic BRK_AUX_OPEN,
  input wire logic BRK_READY,
  input wire logic PLUG_REMOVED,
  input wire logic TRK_AUX_CLOSED,
  input wire logic TRK_AUX_OPEN,
  input wire logic PROT_CLOSE,
  input wire logic PROT_OPEN,
  output wire logic BRK_CLOSE_CMD,
  output wire logic BRK_OPEN_CMD,
  output wire logic TRK_INSERT_CMD,
  output wire logic TRK_WITHDRAW_CMD,
  output wire logic [POS_W-1:0] BRK_POS,
  output wire logic [POS_W-1:0] TRK_POS,
  output logic PLUG_WITHDRAWN
);

  // Bus capture state
  logic aw_have_reg;
  logic w_have_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [STRB_W-1:0] wstrb_reg;
  logic wr_fire;
  logic [DATA_W-1:0] rd_word;

  // Software visible registers
  logic [DATA_W-1:0] ctrl_reg;
  logic [DATA_W-1:0] brk_time_reg;
  logic [DATA_W-1:0] trk_time_reg;
  logic [DATA_W-1:0] settle_reg;
  logic [CMD_W-1:0] cmd_pulse_reg;
  logic refused_reg;
  logic [DATA_W-1:0] status_word;

  // Command steering
  logic tick;
  logic want_brk_close;
  logic want_brk_open;
  logic withdraw_block;
  logic brk_close_req;
  logic brk_open_req;
  logic trk_withdraw_req;
  logic refuse_evt;
  logic brk_busy;
  logic trk_busy;
  pos_t brk_pos;
  pos_t trk_pos;

  // True for any register offset in the map
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == CTRL_OFFS) || (a == CMD_OFFS) ||
                (a == STATUS_OFFS) || (a == BRK_TIME_OFFS) ||
                (a == TRK_TIME_OFFS) || (a == SETTLE_OFFS);
  endfunction

  // Merge written bytes into the old word
  function automatic logic [DATA_W-1:0] apply_strb(
    input logic [DATA_W-1:0] old_word,
    input logic [DATA_W-1:0] new_word,
    input logic [STRB_W-1:0] strb
  );
    logic [DATA_W-1:0] res;
    res = old_word;
    for (int i = 0; i < STRB_W; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    apply_strb = res;
  endfunction

  // A unit never loses its last feedback contact
  function automatic logic [DATA_W-1:0] keep_feedback(
    input logic [DATA_W-1:0] old_word,
    input logic [DATA_W-1:0] new_word
  );
    logic [DATA_W-1:0] res;
    res = new_word & CTRL_MASK;
    if (!res[CTRL_BRK_CL_BIT] && !res[CTRL_BRK_OP_BIT]) begin
      res[CTRL_BRK_CL_BIT] = old_word[CTRL_BRK_CL_BIT];
      res[CTRL_BRK_OP_BIT] = old_word[CTRL_BRK_OP_BIT];
    end
    if (!res[CTRL_TRK_CL_BIT] && !res[CTRL_TRK_OP_BIT]) begin
      res[CTRL_TRK_CL_BIT] = old_word[CTRL_TRK_CL_BIT];
      res[CTRL_TRK_OP_BIT] = old_word[CTRL_TRK_OP_BIT];
    end
    keep_feedback = res;
  endfunction

  // Write address channel; held off until the response is taken
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      AWREADY <= 1'b1;
      aw_have_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (AWVALID && AWREADY) begin
      AWREADY <= 1'b0;
      aw_have_reg <= 1'b1;
      awaddr_reg <= AWADDR;
    end else if (BVALID && BREADY) begin
      AWREADY <= 1'b1;
      aw_have_reg <= 1'b0;
    end
  end

  // Write data channel, independent of the address
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      WREADY <= 1'b1;
      w_have_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (WVALID && WREADY) begin
      WREADY <= 1'b0;
      w_have_reg <= 1'b1;
      wdata_reg <= WDATA;
      wstrb_reg <= WSTRB;
    end else if (BVALID && BREADY) begin
      WREADY <= 1'b1;
      w_have_reg <= 1'b0;
    end
  end

  // Both halves present and no response pending
  assign wr_fire = aw_have_reg & w_have_reg & ~BVALID;

  // Write response, error for unmapped offsets
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end else if (wr_fire) begin
      BVALID <= 1'b1;
      BRESP <= is_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (BVALID && BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // Control and timing registers
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctrl_reg <= CTRL_RESET;
      brk_time_reg <= TIME_RESET;
      trk_time_reg <= TIME_RESET;
      settle_reg <= SETTLE_RESET;
    end else if (wr_fire) begin
      if (awaddr_reg == CTRL_OFFS) begin
        ctrl_reg <= keep_feedback(ctrl_reg,
          apply_strb(ctrl_reg, wdata_reg, wstrb_reg)); // R8
      end
      if (awaddr_reg == BRK_TIME_OFFS) begin
        brk_time_reg <= apply_strb(brk_time_reg, wdata_reg,
          wstrb_reg); // R11
      end
      if (awaddr_reg == TRK_TIME_OFFS) begin
        trk_time_reg <= apply_strb(trk_time_reg, wdata_reg,
          wstrb_reg); // R11
      end
      if (awaddr_reg == SETTLE_OFFS) begin
        settle_reg <= apply_strb(settle_reg, wdata_reg, wstrb_reg);
      end
    end
  end

  // Command word is write-only; each write with byte 0 enabled gives one pulse
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cmd_pulse_reg <= '0;
    end else if (wr_fire && awaddr_reg == CMD_OFFS && wstrb_reg[0]) begin
      cmd_pulse_reg <= wdata_reg[CMD_W-1:0];
    end else begin
      cmd_pulse_reg <= '0;
    end
  end

  // Request gating for plug, readiness and interlock
  always_comb begin
    want_brk_close = cmd_pulse_reg[CMD_BRK_CLOSE] |
                     (ctrl_reg[CTRL_PROT_BIT] & PROT_CLOSE); // R12
    want_brk_open = cmd_pulse_reg[CMD_BRK_OPEN] |
                    (ctrl_reg[CTRL_PROT_BIT] & PROT_OPEN); // R12
    withdraw_block = ctrl_reg[CTRL_ILOCK_BIT] &
                     (brk_pos == POS_CLOSED); // R6
    brk_close_req = want_brk_close & BRK_READY & ~PLUG_REMOVED; // R4
    brk_open_req = want_brk_open & ~PLUG_REMOVED; // R4
    trk_withdraw_req = cmd_pulse_reg[CMD_TRK_WITHDRAW] &
                       ~withdraw_block; // R6
    refuse_evt = (want_brk_close & ~brk_close_req) |
                 (want_brk_open & ~brk_open_req) |
                 (cmd_pulse_reg[CMD_TRK_WITHDRAW] & withdraw_block);
  end

  // Sticky refusal flag; a new refusal beats the clear
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      refused_reg <= 1'b0;
    end else if (refuse_evt) begin
      refused_reg <= 1'b1;
    end else if (wr_fire && awaddr_reg == STATUS_OFFS && wstrb_reg[0] &&
                 wdata_reg[STAT_REFUSED_BIT]) begin
      refused_reg <= 1'b0;
    end
  end

  // Plug state for status and the output pin
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      PLUG_WITHDRAWN <= 1'b0;
    end else begin
      PLUG_WITHDRAWN <= PLUG_REMOVED; // R2
    end
  end

  // Status word assembly
  always_comb begin
    status_word = '0;
    status_word[STAT_BRK_POS_LSB +: POS_W] = brk_pos; // R1
    status_word[STAT_TRK_POS_LSB +: POS_W] = trk_pos; // R1
    status_word[STAT_PLUG_BIT] = PLUG_WITHDRAWN; // R2
    status_word[STAT_READY_BIT] = BRK_READY;
    status_word[STAT_REFUSED_BIT] = refused_reg;
    status_word[STAT_BLOCK_BIT] = withdraw_block;
    status_word[STAT_CMD_LSB + CMD_BRK_CLOSE] = BRK_CLOSE_CMD;
    status_word[STAT_CMD_LSB + CMD_BRK_OPEN] = BRK_OPEN_CMD;
    status_word[STAT_CMD_LSB + CMD_TRK_INSERT] = TRK_INSERT_CMD;
    status_word[STAT_CMD_LSB + CMD_TRK_WITHDRAW] = TRK_WITHDRAW_CMD;
    status_word[STAT_BUSY_LSB] = brk_busy;
    status_word[STAT_BUSY_LSB + 1] = trk_busy;
  end

  // Read data select; the command word reads as zero
  always_comb begin
    case (ARADDR)
      CTRL_OFFS: rd_word = ctrl_reg;
      STATUS_OFFS: rd_word = status_word;
      BRK_TIME_OFFS: rd_word = brk_time_reg;
      TRK_TIME_OFFS: rd_word = trk_time_reg;
      SETTLE_OFFS: rd_word = settle_reg;
      default: rd_word = '0;
    endcase
  end

  // Read channel, one read in flight
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= '0;
      RRESP <= RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RDATA <= rd_word;
      RRESP <= is_mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
    end
  end

  // Shared timer tick for both units
  tick_gen #(
    .PERIOD(TICK_CYCLES)
  ) u_tick (
    .clk(CLOCK),
    .rst(RST),
    .tick(tick)
  );

  // Breaker: both contacts, ready and plug removal
  switchgear_unit u_breaker (
    .clk(CLOCK),
    .rst(RST),
    .tick(tick),
    .aux_closed(BRK_AUX_CLOSED), // R7
    .aux_open(BRK_AUX_OPEN),
    .closed_used(ctrl_reg[CTRL_BRK_CL_BIT]),
    .open_used(ctrl_reg[CTRL_BRK_OP_BIT]),
    .force_open(PLUG_REMOVED), // R3
    .close_req(brk_close_req),
    .open_req(brk_open_req),
    .close_time(brk_time_reg[CLOSE_T_LSB +: TIME_W]),
    .open_time(brk_time_reg[OPEN_T_LSB +: TIME_W]),
    .settle_time(settle_reg[BRK_SETTLE_LSB +: TIME_W]),
    .pos(brk_pos),
    .close_cmd(BRK_CLOSE_CMD),
    .open_cmd(BRK_OPEN_CMD),
    .busy(brk_busy)
  );

  // Truck: contacts only; withdrawal gated by the breaker interlock
  switchgear_unit u_truck (
    .clk(CLOCK),
    .rst(RST),
    .tick(tick),
    .aux_closed(TRK_AUX_CLOSED), // R7
    .aux_open(TRK_AUX_OPEN),
    .closed_used(ctrl_reg[CTRL_TRK_CL_BIT]),
    .open_used(ctrl_reg[CTRL_TRK_OP_BIT]),
    .force_open(1'b0), // R5
    .close_req(cmd_pulse_reg[CMD_TRK_INSERT]),
    .open_req(trk_withdraw_req),
    .close_time(trk_time_reg[CLOSE_T_LSB +: TIME_W]),
    .open_time(trk_time_reg[OPEN_T_LSB +: TIME_W]),
    .settle_time(settle_reg[TRK_SETTLE_LSB +: TIME_W]),
    .pos(trk_pos),
    .close_cmd(TRK_INSERT_CMD),
    .open_cmd(TRK_WITHDRAW_CMD),
    .busy(trk_busy)
  );

  // Position codes straight from the unit flops
  assign BRK_POS = brk_pos;
  assign TRK_POS = trk_pos;

endmodule
`default_nettype wire

// file: dv/switchgear_partner.sv
// Switchgear contacts answering relay commands
`timescale 1ns/100ps
`default_nettype none
module switchgear_partner #(
  parameter bit INIT = 1'b0
) (
  input wire logic clk,
  input wire logic stuck,
  input wire logic to_closed,
  input wire logic to_open,
  output logic aux_closed,
  output logic aux_open
);
  int cnt = 0;
  initial begin
    aux_closed = INIT;
    aux_open = !INIT;
  end
  // Contacts drop in travel; stuck never arrives
  always @(posedge clk) begin
    if (to_closed || to_open) begin
      cnt <= cnt + 1;
      aux_closed <= !stuck && cnt >= 12 && to_closed;
      aux_open <= !stuck && cnt >= 12 && to_open;
    end else begin
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// file: dv/withdrawable_switchgear_supervision_checker.sv
// Port assertions for the switchgear supervisor
`timescale 1ns/100ps
`default_nettype none
module withdrawable_switchgear_supervision_checker
  import sg_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [DATA_W-1:0] RDATA,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic BRK_AUX_CLOSED,
  input wire logic BRK_AUX_OPEN,
  input wire logic PLUG_REMOVED,
  input wire logic BRK_CLOSE_CMD,
  input wire logic BRK_OPEN_CMD,
  input wire logic [POS_W-1:0] BRK_POS,
  input wire logic PLUG_WITHDRAWN
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  // Reset timeout plus slack
  localparam int MAX_CMD = 100 * TICK_CYCLES + 2;
  int run_reg;
  // Breaker command length
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      run_reg <= 0;
    end else if (BRK_CLOSE_CMD || BRK_OPEN_CMD) begin
      run_reg <= run_reg + 1;
    end else begin
      run_reg <= 0;
    end
  end
  a_plug_follows: assert property (1'b1 |=>
    PLUG_WITHDRAWN == $past(PLUG_REMOVED)) else $error("plug status lag");
  a_plug_opens: assert property (PLUG_REMOVED |=>
    BRK_POS == POS_OPEN) else $error("plug does not force open");
  a_plug_no_cmd: assert property (PLUG_REMOVED |=>
    !BRK_CLOSE_CMD && !BRK_OPEN_CMD) else $error("command with plug out");
  a_close_ends: assert property (BRK_CLOSE_CMD && BRK_AUX_CLOSED
    && !BRK_AUX_OPEN |=> !BRK_CLOSE_CMD) else $error("close not dropped");
  a_open_ends: assert property (BRK_OPEN_CMD && BRK_AUX_OPEN
    && !BRK_AUX_CLOSED |=> !BRK_OPEN_CMD) else $error("open not dropped");
  a_cmd_bounded: assert property (run_reg <= MAX_CMD)
    else $error("command longer than timeout");
  a_equal_no_end: assert property (BRK_AUX_CLOSED == BRK_AUX_OPEN
    && !PLUG_REMOVED |=> BRK_POS != POS_OPEN && BRK_POS != POS_CLOSED)
    else $error("equal contacts show end position");
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID
    && !ARREADY) else $error("read answer late");
  a_read_holds: assert property (RVALID && !RREADY |=> RVALID
    && $stable(RDATA)) else $error("read data not held");
  c_fault: cover property (BRK_POS == POS_FAULT);
  c_plug_closed: cover property (PLUG_WITHDRAWN && BRK_AUX_CLOSED);
  c_open_cmd: cover property ($rose(BRK_OPEN_CMD));
endmodule
bind withdrawable_switchgear_supervision
  withdrawable_switchgear_supervision_checker #(.TICK_CYCLES(TICK_CYCLES))
  chk (.CLOCK, .RST, .ARVALID, .ARREADY, .RDATA, .RVALID, .RREADY,
  .BRK_AUX_CLOSED, .BRK_AUX_OPEN, .PLUG_REMOVED, .BRK_CLOSE_CMD,
  .BRK_OPEN_CMD, .BRK_POS, .PLUG_WITHDRAWN);
`default_nettype wire

// file: dv/withdrawable_switchgear_supervision_bench.sv
// Bench for the switchgear supervisor
`timescale 1ns/100ps
`default_nettype none
module withdrawable_switchgear_supervision_bench;
  import sg_pkg::*;
  typedef struct {
    bit wr;
    logic [1:0] resp;
    logic [31:0] data, mask;
  } note_t;
  note_t exq[$];
  logic CLOCK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, b_stuck;
  logic [7:0] AWADDR, ARADDR, ra;
  logic [31:0] WDATA, RDATA, v;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP, BRK_POS, TRK_POS;
  logic BRK_AUX_CLOSED, BRK_AUX_OPEN, BRK_READY, PLUG_REMOVED;
  logic TRK_AUX_CLOSED, TRK_AUX_OPEN, PROT_CLOSE, PROT_OPEN;
  logic BRK_CLOSE_CMD, BRK_OPEN_CMD, TRK_INSERT_CMD, TRK_WITHDRAW_CMD;
  logic PLUG_WITHDRAWN;
  int bad_count = 0;
  int checks = 0;
  int seed = 23;
  withdrawable_switchgear_supervision #(.TICK_CYCLES(10)) dut (.CLOCK,
    .RST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
    .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP,
    .RVALID, .RREADY, .BRK_AUX_CLOSED, .BRK_AUX_OPEN, .BRK_READY,
    .PLUG_REMOVED, .TRK_AUX_CLOSED, .TRK_AUX_OPEN, .PROT_CLOSE, .PROT_OPEN,
    .BRK_CLOSE_CMD, .BRK_OPEN_CMD, .TRK_INSERT_CMD, .TRK_WITHDRAW_CMD,
    .BRK_POS, .TRK_POS, .PLUG_WITHDRAWN);
  switchgear_partner #(.INIT(1'b0)) brk (.clk(CLOCK), .stuck(b_stuck),
    .to_closed(BRK_CLOSE_CMD), .to_open(BRK_OPEN_CMD),
    .aux_closed(BRK_AUX_CLOSED), .aux_open(BRK_AUX_OPEN));
  switchgear_partner #(.INIT(1'b1)) trk (.clk(CLOCK), .stuck(1'b0),
    .to_closed(TRK_INSERT_CMD), .to_open(TRK_WITHDRAW_CMD),
    .aux_closed(TRK_AUX_CLOSED), .aux_open(TRK_AUX_OPEN));

  task automatic cmp_resp(input string what, logic [1:0] e, g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp_data(input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH rdata expected %h seen %h", e, g);
    end
  endtask
  // One bus transfer; note queued first
  task automatic bus(input bit wr, logic [7:0] a,
    logic [31:0] d, logic [1:0] r, logic [31:0] m);
    bit aw, w, b;
    exq.push_back('{wr, r, d, m});
    @(posedge CLOCK);
    aw = 1;
    w = wr;
    b = 1;
    AWADDR <= a;
    ARADDR <= a;
    WDATA <= d;
    AWVALID <= wr;
    WVALID <= wr;
    BREADY <= wr;
    ARVALID <= !wr;
    RREADY <= !wr;
    while (aw || w || b) begin
      @(posedge CLOCK);
      if (aw && (wr ? AWREADY : ARREADY)) begin
        aw = 0;
        AWVALID <= 0;
        ARVALID <= 0;
      end
      if (w && WREADY) begin
        w = 0;
        WVALID <= 0;
      end
      if (b && (wr ? BVALID : RVALID)) begin
        b = 0;
        BREADY <= 0;
        RREADY <= 0;
      end
    end
  endtask
  // Bounded wait for both positions
  task automatic wait_pos(input logic [1:0] bp, tp);
    for (int n = 0; n < 600 && (BRK_POS !== bp || TRK_POS !== tp); n++)
      @(posedge CLOCK);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Oldest note against each bus answer
  always @(posedge CLOCK) begin
    note_t n;
    if ((BVALID && BREADY) || (RVALID && RREADY)) begin
      if (exq.size() == 0) begin
        bad_count++;
        $display("MISMATCH queue expected note seen none");
      end else begin
        n = exq.pop_front();
        cmp_resp("resp", n.resp, n.wr ? BRESP : RRESP);
        if (!n.wr) cmp_data(n.data & n.mask, RDATA & n.mask);
      end
    end
  end
  initial begin
    CLOCK = 0;
    forever #2.5 CLOCK = ~CLOCK;
  end
  // Few hundred cycles needed; cut at 20000
  initial begin
    #100000;
    bad_count++;
    $display("MISMATCH watchdog expected done seen hang");
    give_verdict();
  end
  initial begin
    {RST, BRK_READY} = 2'b11;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, b_stuck} = 6'h0;
    {PLUG_REMOVED, PROT_CLOSE, PROT_OPEN} = 3'h0;
    {AWADDR, ARADDR, WDATA, WSTRB} = {16'h0, 32'h0, 4'hf};
    repeat (4) @(posedge CLOCK);
    RST <= 0;
    bus(0, CTRL_OFFS, CTRL_RESET, RESP_OKAY, '1);
    bus(0, STATUS_OFFS, 32'h29, RESP_OKAY, 32'hffff);
    bus(0, 8'h18, 32'h0, RESP_SLVERR, '1);
    bus(1, 8'h18, 32'h1, RESP_SLVERR, 0);
    bus(0, CMD_OFFS, 32'h0, RESP_OKAY, '1);
    for (int i = 0; i < 3; i++) begin
      v = $random(seed);
      ra = BRK_TIME_OFFS + 8'(4 * i);
      bus(0, ra, i < 2 ? TIME_RESET : 0, RESP_OKAY, '1);
      bus(1, ra, v, RESP_OKAY, 0);
      bus(0, ra, v, RESP_OKAY, '1);
      bus(1, ra, i < 2 ? 32'h5_0005 : 0, 0, 0);
    end
    $display("test registers done");
    // Close: mid while moving, then closed
    bus(1, CMD_OFFS, 32'h1, RESP_OKAY, 0);
    bus(0, STATUS_OFFS, 32'h1128, RESP_OKAY, 32'hffff);
    wait_pos(POS_CLOSED, POS_CLOSED);
    bus(0, STATUS_OFFS, 32'h2a, RESP_OKAY, 32'hffff);
    $display("test close done");
    // Plug out on closed breaker; open refused
    PLUG_REMOVED <= 1;
    BRK_READY <= 0;
    bus(1, CMD_OFFS, 32'h2, RESP_OKAY, 0);
    bus(0, STATUS_OFFS, 32'h59, RESP_OKAY, 32'hffff);
    PLUG_REMOVED <= 0;
    BRK_READY <= 1;
    bus(1, STATUS_OFFS, 32'h40, RESP_OKAY, 0);
    wait_pos(POS_CLOSED, POS_CLOSED);
    bus(0, STATUS_OFFS, 32'h2a, RESP_OKAY, 32'hffff);
    $display("test plug done");
    // Interlock holds truck while breaker closed
    bus(1, CTRL_OFFS, 32'h3d, RESP_OKAY, 0);
    bus(1, CMD_OFFS, 32'h8, RESP_OKAY, 0);
    bus(0, STATUS_OFFS, 32'hea, RESP_OKAY, 32'hffff);
    bus(1, STATUS_OFFS, 32'h40, RESP_OKAY, 0);
    bus(1, CMD_OFFS, 32'h2, RESP_OKAY, 0);
    wait_pos(POS_OPEN, POS_CLOSED);
    bus(1, CMD_OFFS, 32'h8, RESP_OKAY, 0);
    wait_pos(POS_OPEN, POS_OPEN);
    bus(1, CMD_OFFS, 32'h1, RESP_OKAY, 0);
    wait_pos(POS_CLOSED, POS_OPEN);
    bus(0, STATUS_OFFS, 32'h26, RESP_OKAY, 32'hff7f);
    $display("test interlock done");
    // Protection trip, breaker stuck mid-travel
    bus(1, CTRL_OFFS, 32'h3e, RESP_OKAY, 0);
    b_stuck <= 1;
    PROT_OPEN <= 1;
    @(posedge CLOCK);
    PROT_OPEN <= 0;
    wait_pos(POS_FAULT, POS_OPEN);
    bus(0, STATUS_OFFS, 32'h27, RESP_OKAY, 32'hffff);
    b_stuck <= 0;
    bus(1, CMD_OFFS, 32'h6, RESP_OKAY, 0);
    wait_pos(POS_OPEN, POS_CLOSED);
    bus(0, STATUS_OFFS, 32'h29, RESP_OKAY, 32'hffff);
    $display("test fault done");
    give_verdict();
  end
endmodule
`default_nettype wire
